// File: pkg/sec_pkg.sv
package sec_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] SEC_CMD_OFS = 12'h030;
  localparam logic [11:0] SEC_DATA_OFS = 12'h034;
  localparam int SEC_BUSY_BIT = 31;
  localparam int SEC_OP_HI = 30;
  localparam int SEC_OP_LO = 28;
  localparam int SEC_TOUT_BIT = 10;
  localparam int SEC_LOADED_BIT = 9;
  localparam int SEC_ADDR_HI = 8;
  localparam logic [8:0] SEC_ADDR_RST = 9'h000;
  localparam logic [7:0] SEC_DATA_RST = 8'h00;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEC_OP_READ = 3'h0,
    SEC_OP_ERASE_WRITE_DISABLE = 3'h1,
    SEC_OP_ERASE_WRITE_ENABLE = 3'h2,
    SEC_OP_WRITE = 3'h3,
    SEC_OP_WRITE_ALL = 3'h4,
    SEC_OP_ERASE = 3'h5,
    SEC_OP_ERASE_ALL = 3'h6,
    SEC_OP_RELOAD = 3'h7
  } sec_op_e;

  typedef enum logic [3:0] {
    SEC_ST_IDLE = 4'h1,
    SEC_ST_SEND = 4'h2,
    SEC_ST_GAP = 4'h4,
    SEC_ST_POLL = 4'h8
  } sec_state_e;

  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam int SEC_FRAME_W = 20;
  localparam logic [4:0] SEC_HDR_BITS = 5'h0C;
  localparam logic [4:0] SEC_FULL_BITS = 5'h14;
  localparam logic [1:0] SEC_MW_READ = 2'h2;
  localparam logic [1:0] SEC_MW_WRITE = 2'h1;
  localparam logic [1:0] SEC_MW_ERASE = 2'h3;
  localparam logic [1:0] SEC_MW_EXT = 2'h0;
  localparam logic [1:0] SEC_EXT_ERASE_WRITE_ENABLE_OP = 2'h3;
  localparam logic [1:0] SEC_EXT_ERASE_WRITE_DISABLE_OP = 2'h0;
  localparam logic [1:0] SEC_EXT_WRITE_ALL_OP = 2'h1;
  localparam logic [1:0] SEC_EXT_ERASE_ALL_OP = 2'h2;
  localparam logic [7:0] SEC_SIG_BYTE = 8'hA5;
  localparam logic [8:0] SEC_LOAD_BYTES = 9'h010;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SEC_CLK_MHZ = 250;
  localparam int SEC_TIMEOUT_MS = 30;
  localparam int SEC_TIMEOUT_CYC = SEC_TIMEOUT_MS * 1000 * SEC_CLK_MHZ;
  localparam int SEC_SK_HALF_NS = 100;
  localparam int SEC_SK_HALF_CYC = (SEC_SK_HALF_NS * SEC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SEC_SK_HALF_LAST = 8'(SEC_SK_HALF_CYC - 1);
endpackage : sec_pkg

// File: core/sec_serial_shift.sv
`timescale 1ns/1ps
module sec_serial_shift import sec_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [4:0] nbits,
  input wire logic [SEC_FRAME_W-1:0] frame,
  input wire logic di,
  output logic sk,
  output logic dout,
  output logic done,
  output logic [7:0] rx
);
  logic [SEC_FRAME_W-1:0] shreg_r;
  logic [4:0] cnt_r;
  logic [7:0] half_r;
  logic active_r;
  logic sk_r;
  logic done_r;
  logic [7:0] rx_r;

  // ----------------------------------------
  // bit engine, msb first, sample on rising sk
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg_r <= '0;
      cnt_r <= 5'h00;
      half_r <= 8'h00;
      active_r <= 1'b0;
      sk_r <= 1'b0;
      done_r <= 1'b0;
      rx_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        shreg_r <= frame;
        cnt_r <= nbits;
        half_r <= 8'h00;
        active_r <= 1'b1;
        sk_r <= 1'b0;
      end else if (active_r) begin
        if (half_r == SEC_SK_HALF_LAST) begin
          half_r <= 8'h00;
          if (!sk_r) begin
            sk_r <= 1'b1;
            rx_r <= {rx_r[6:0], di};
          end else begin
            sk_r <= 1'b0;
            shreg_r <= {shreg_r[SEC_FRAME_W-2:0], 1'b0};
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
              active_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end else begin
          half_r <= half_r + 8'h01;
        end
      end
    end
  end

  assign sk = sk_r;
  assign dout = shreg_r[SEC_FRAME_W-1] & active_r;
  assign done = done_r;
  assign rx = rx_r;
endmodule : sec_serial_shift

// File: core/sec_timeout_timer.sv
`timescale 1ns/1ps
module sec_timeout_timer #(
  parameter int CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic expire
);
  logic [31:0] cnt_r;
  logic expire_r;

  // ----------------------------------------
  // counts while running, restarts when idle
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0000_0000;
      expire_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 32'h0000_0000;
      expire_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      expire_r <= (cnt_r == 32'(CYCLES - 2));
    end
  end

  assign expire = expire_r;
endmodule : sec_timeout_timer

// File: core/sec_eeprom_cmd.sv
// Summary of operation
// - writing one to busy bit 31 runs the held opcode at the held address
// - busy stays one until the operation finishes or times out
// - a write with no memory and data input low keeps busy until timeout, then clears
// - busy is one after reset or USB reset until default load ends
// - opcode bits 30:28 decode read, disable, enable, write, write all, erase, erase all, reload
// - read fetches the addressed byte into the byte buffer
// - write stores the byte buffer at the addressed location
// - write all stores the byte buffer into every location
// - erase clears the addressed location
// - erase all starts a bulk erase of the memory
// - reload fails unless the first byte holds A5h
// - a failed reload leaves loaded contents untouched
// - no response within 30 ms ends the operation and sets flag bit 10
// - with data input high nothing times out; busy clears at sequence end
// - with data input low only erase and write opcodes time out
// - loaded flag bit 9 sets after a good load; write one clears it
// - address bits 8:0 select the location; reset value zero
// - byte buffer holds the 8-bit read or write byte in bits 7:0
`timescale 1ns/1ps
module sec_eeprom_cmd import sec_pkg::*; #(
  parameter int TIMEOUT_CYCLES = SEC_TIMEOUT_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic USB_RST,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic EE_CS,
  output logic EE_SK,
  output logic EE_DO,
  input wire logic EE_DI,
  output logic CFG_LOAD_VALID,
  output logic [8:0] CFG_LOAD_ADDR,
  output logic [7:0] CFG_LOAD_DATA
);
  sec_state_e state_r;
  sec_op_e op_r;
  logic busy_r;
  logic [8:0] addr_r;
  logic [7:0] data_r;
  logic tout_r;
  logic loaded_r;
  logic load_pend_r;
  logic loading_r;
  logic [8:0] load_idx_r;
  logic poll_next_r;
  logic [7:0] gap_r;
  logic cs_r;
  logic shift_start_r;
  logic [31:0] rdata_r;
  logic cfg_valid_r;
  logic [8:0] cfg_addr_r;
  logic [7:0] cfg_data_r;
  logic cmd_wr;
  logic data_wr;
  logic sh_done;
  logic [7:0] sh_rx;
  logic tmr_expire;
  logic timeout_evt;
  logic sh_done_evt;
  logic load_byte_evt;
  logic sig_bad;
  logic load_ok_evt;
  logic read_done_evt;
  logic op_polls;
  logic [SEC_FRAME_W-1:0] frame;
  logic [4:0] nbits;

  // ----------------------------------------
  // frame builder
  // ----------------------------------------
  function automatic logic [SEC_FRAME_W-1:0] frame_f(sec_op_e op, logic [8:0] a, logic [7:0] d);
    logic [SEC_FRAME_W-1:0] f;
    case (op)
      SEC_OP_ERASE_WRITE_DISABLE: f = {1'b1, SEC_MW_EXT, SEC_EXT_ERASE_WRITE_DISABLE_OP, 7'h00, 8'h00};
      SEC_OP_ERASE_WRITE_ENABLE: f = {1'b1, SEC_MW_EXT, SEC_EXT_ERASE_WRITE_ENABLE_OP, 7'h00, 8'h00};
      SEC_OP_WRITE: f = {1'b1, SEC_MW_WRITE, a, d};
      SEC_OP_WRITE_ALL: f = {1'b1, SEC_MW_EXT, SEC_EXT_WRITE_ALL_OP, 7'h00, d};
      SEC_OP_ERASE: f = {1'b1, SEC_MW_ERASE, a, 8'h00};
      SEC_OP_ERASE_ALL: f = {1'b1, SEC_MW_EXT, SEC_EXT_ERASE_ALL_OP, 7'h00, 8'h00};
      default: f = {1'b1, SEC_MW_READ, a, 8'h00};
    endcase
    return f;
  endfunction : frame_f

  assign op_polls = !loading_r && (op_r == SEC_OP_WRITE || op_r == SEC_OP_WRITE_ALL ||
                    op_r == SEC_OP_ERASE || op_r == SEC_OP_ERASE_ALL);
  assign frame = loading_r ? frame_f(SEC_OP_READ, load_idx_r, 8'h00) : frame_f(op_r, addr_r, data_r);
  assign nbits = (loading_r || op_r == SEC_OP_READ || op_r == SEC_OP_WRITE || op_r == SEC_OP_WRITE_ALL) ?
                 SEC_FULL_BITS : SEC_HDR_BITS;

  // ----------------------------------------
  // serial engine and timer
  // ----------------------------------------
  sec_serial_shift u_shift (
    .clk(MCLK),
    .rst(RST),
    .start(shift_start_r),
    .nbits(nbits),
    .frame(frame),
    .di(EE_DI),
    .sk(EE_SK),
    .dout(EE_DO),
    .done(sh_done),
    .rx(sh_rx)
  );

  sec_timeout_timer #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_timer (
    .clk(MCLK),
    .rst(RST),
    .run(state_r != SEC_ST_IDLE),
    .expire(tmr_expire)
  );

  // ----------------------------------------
  // events
  // ----------------------------------------
  assign cmd_wr = REG_WR && (REG_ADDR == SEC_CMD_OFS);
  assign data_wr = REG_WR && (REG_ADDR == SEC_DATA_OFS);
  assign timeout_evt = (state_r != SEC_ST_IDLE) && tmr_expire && !USB_RST;
  assign sh_done_evt = (state_r == SEC_ST_SEND) && sh_done && !tmr_expire && !USB_RST;
  assign load_byte_evt = sh_done_evt && loading_r;
  assign sig_bad = load_byte_evt && (load_idx_r == 9'h000) && (sh_rx != SEC_SIG_BYTE);
  assign load_ok_evt = load_byte_evt && (load_idx_r == SEC_LOAD_BYTES - 9'h001);
  assign read_done_evt = sh_done_evt && !loading_r && (op_r == SEC_OP_READ);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= SEC_ST_IDLE;
      busy_r <= 1'b1;
      load_pend_r <= 1'b1;
      loading_r <= 1'b0;
      load_idx_r <= 9'h000;
      poll_next_r <= 1'b0;
      gap_r <= 8'h00;
      cs_r <= 1'b0;
      shift_start_r <= 1'b0;
    end else begin
      shift_start_r <= 1'b0;
      if (USB_RST) begin
        state_r <= SEC_ST_IDLE;
        busy_r <= 1'b1;
        load_pend_r <= 1'b1;
        loading_r <= 1'b0;
        cs_r <= 1'b0;
      end else if (timeout_evt) begin
        state_r <= SEC_ST_IDLE;
        busy_r <= 1'b0;
        loading_r <= 1'b0;
        cs_r <= 1'b0;
      end else begin
        case (state_r)
          SEC_ST_IDLE: begin
            if (busy_r) begin
              state_r <= SEC_ST_SEND;
              cs_r <= 1'b1;
              shift_start_r <= 1'b1;
              if (load_pend_r || op_r == SEC_OP_RELOAD) begin
                loading_r <= 1'b1;
                load_idx_r <= 9'h000;
                load_pend_r <= 1'b0;
              end
            end else if (cmd_wr && REG_WDATA[SEC_BUSY_BIT]) begin
              busy_r <= 1'b1;
            end
          end
          SEC_ST_SEND: begin
            if (sh_done) begin
              cs_r <= 1'b0;
              gap_r <= 8'h00;
              if (op_polls) begin
                state_r <= SEC_ST_GAP;
                poll_next_r <= 1'b1;
              end else if (loading_r && !sig_bad && !load_ok_evt) begin
                state_r <= SEC_ST_GAP;
                poll_next_r <= 1'b0;
                load_idx_r <= load_idx_r + 9'h001;
              end else begin
                state_r <= SEC_ST_IDLE;
                busy_r <= 1'b0;
                loading_r <= 1'b0;
              end
            end
          end
          SEC_ST_GAP: begin
            if (gap_r == SEC_SK_HALF_LAST) begin
              cs_r <= 1'b1;
              if (poll_next_r) begin
                state_r <= SEC_ST_POLL;
              end else begin
                state_r <= SEC_ST_SEND;
                shift_start_r <= 1'b1;
              end
            end else begin
              gap_r <= gap_r + 8'h01;
            end
          end
          SEC_ST_POLL: begin
            if (EE_DI) begin
              state_r <= SEC_ST_IDLE;
              busy_r <= 1'b0;
              cs_r <= 1'b0;
            end
          end
          default: begin
            state_r <= SEC_ST_IDLE;
            busy_r <= 1'b0;
            cs_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // command fields and byte buffer
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      op_r <= SEC_OP_READ;
      addr_r <= SEC_ADDR_RST;
    end else if (cmd_wr && !busy_r) begin
      op_r <= sec_op_e'(REG_WDATA[SEC_OP_HI:SEC_OP_LO]);
      addr_r <= REG_WDATA[SEC_ADDR_HI:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      data_r <= SEC_DATA_RST;
    end else if (read_done_evt) begin
      data_r <= sh_rx;
    end else if (data_wr && !busy_r) begin
      data_r <= REG_WDATA[7:0];
    end
  end

  // ----------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tout_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      if (timeout_evt) begin
        tout_r <= 1'b1;
      end else if (cmd_wr && REG_WDATA[SEC_TOUT_BIT]) begin
        tout_r <= 1'b0;
      end
      if (load_ok_evt) begin
        loaded_r <= 1'b1;
      end else if (cmd_wr && REG_WDATA[SEC_LOADED_BIT]) begin
        loaded_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // configuration load output
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg_valid_r <= 1'b0;
      cfg_addr_r <= 9'h000;
      cfg_data_r <= 8'h00;
    end else begin
      cfg_valid_r <= load_byte_evt && (load_idx_r != 9'h000);
      if (load_byte_evt) begin
        cfg_addr_r <= load_idx_r;
        cfg_data_r <= sh_rx;
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (REG_RD && REG_ADDR == SEC_CMD_OFS) begin
      rdata_r <= {busy_r, op_r, 17'h00000, tout_r, loaded_r, addr_r};
    end else if (REG_RD && REG_ADDR == SEC_DATA_OFS) begin
      rdata_r <= {24'h000000, data_r};
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata_r;
  assign EE_CS = cs_r;
  assign CFG_LOAD_VALID = cfg_valid_r;
  assign CFG_LOAD_ADDR = cfg_addr_r;
  assign CFG_LOAD_DATA = cfg_data_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_GO_START: assert property (@(posedge MCLK) disable iff (RST)
    state_r == SEC_ST_IDLE && busy_r && !USB_RST |=> state_r == SEC_ST_SEND ##1 shift_start_r == 1'b0)
    else $error("busy command did not start");
  AST_BUSY_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    state_r != SEC_ST_IDLE |-> busy_r)
    else $error("busy low while running");
  AST_TOUT_END: assert property (@(posedge MCLK) disable iff (RST)
    timeout_evt |=> tout_r && !busy_r && state_r == SEC_ST_IDLE && !EE_CS)
    else $error("timeout did not end operation");
  AST_RESET_BUSY: assert property (@(posedge MCLK) disable iff (RST)
    $past(USB_RST) && !USB_RST |-> busy_r && state_r == SEC_ST_IDLE ##1 state_r == SEC_ST_SEND && loading_r)
    else $error("reset did not start default load");
  AST_READ_DATA: assert property (@(posedge MCLK) disable iff (RST)
    read_done_evt |=> data_r == $past(sh_rx) && !busy_r)
    else $error("read byte not captured");
  AST_SIG_FAIL: assert property (@(posedge MCLK) disable iff (RST)
    sig_bad |=> !CFG_LOAD_VALID && state_r == SEC_ST_IDLE && $stable(loaded_r) && !loading_r)
    else $error("bad signature not refused");
  AST_POLL_END: assert property (@(posedge MCLK) disable iff (RST)
    state_r == SEC_ST_POLL && EE_DI && !tmr_expire && !USB_RST |=> state_r == SEC_ST_IDLE && !busy_r)
    else $error("ready memory did not end busy");
  AST_POLL_OPS: assert property (@(posedge MCLK) disable iff (RST)
    state_r == SEC_ST_POLL |-> op_polls && $past(state_r) inside {SEC_ST_GAP, SEC_ST_POLL})
    else $error("non erase or write opcode polling");
  AST_LOADED_SET: assert property (@(posedge MCLK) disable iff (RST)
    load_ok_evt |=> loaded_r && !busy_r)
    else $error("loaded flag not set");
endmodule : sec_eeprom_cmd

// File: bench/sec_eeprom_model.sv
`timescale 1ns/1ps
module sec_eeprom_model #(
  parameter int SLOW_NS = 20000,
  parameter int FAST_NS = 400
) (
  input wire logic EE_CS,
  input wire logic EE_SK,
  input wire logic EE_DO,
  input wire logic present,
  input wire logic pull_lvl,
  input wire logic slow,
  output logic EE_DI
);
  // ------
  // storage and frame capture
  // ------
  logic [7:0] mem [0:511];
  logic [19:0] sr;
  logic [1:0] op;
  logic [8:0] ad;
  logic wen, drv, dval, stat, busy;
  int cnt;
  event prog;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'(i * 3 + 1);
    mem[0] = 8'hA5;
    wen = 1'b0;
    {drv, dval, stat, busy} = 4'h0;
    cnt = 0;
    op = 2'h0;
    ad = 9'h000;
    sr = 20'h0;
  end
  // released line falls to the board pull level
  assign EE_DI = !present ? pull_lvl : (stat && EE_CS) ? !busy : drv ? dval : pull_lvl;
  always @(posedge EE_CS) cnt = 0;
  always @(posedge EE_SK) begin
    if (EE_CS && cnt < 20) begin
      sr = {sr[18:0], EE_DO};
      cnt++;
      if (cnt == 12) begin
        op = sr[10:9];
        ad = sr[8:0];
      end
    end
  end
  always @(negedge EE_SK) begin
    if (EE_CS && op == 2'h2 && cnt >= 12 && cnt < 20) begin
      drv = 1'b1;
      dval = mem[ad][19 - cnt];
    end
  end
  // ------
  // command execution at frame end
  // ------
  always @(negedge EE_CS) begin
    drv = 1'b0;
    if (stat) stat = 1'b0;
    else if (cnt >= 12) begin
      case (op)
        2'h1: if (wen && cnt == 20) begin
          mem[ad] = sr[7:0];
          ->prog;
        end
        2'h3: if (wen) begin
          mem[ad] = 8'hFF;
          ->prog;
        end
        2'h0: case (ad[8:7])
          2'h3: wen = 1'b1;
          2'h0: wen = 1'b0;
          2'h1: if (wen && cnt == 20) begin
            foreach (mem[i]) mem[i] = sr[7:0];
            ->prog;
          end
          default: if (wen) begin
            foreach (mem[i]) mem[i] = 8'hFF;
            ->prog;
          end
        endcase
        default: ;
      endcase
    end
  end
  always begin
    @(prog);
    stat = 1'b1;
    busy = 1'b1;
    #(slow ? SLOW_NS : FAST_NS);
    busy = 1'b0;
  end
endmodule : sec_eeprom_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sec_pkg::*;
  localparam int TOUT = 24000;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic USB_RST = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic EE_CS, EE_SK, EE_DO, EE_DI, CFG_LOAD_VALID;
  logic [8:0] CFG_LOAD_ADDR;
  logic [7:0] CFG_LOAD_DATA;
  logic present = 1'b1;
  logic pull_lvl = 1'b1;
  logic slow = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int n_cfg = 0;
  int cyc = 0;
  int t0;
  logic [31:0] v;
  always #2 MCLK = ~MCLK;
  sec_eeprom_cmd #(.TIMEOUT_CYCLES(TOUT)) DUT (.MCLK(MCLK), .RST(RST), .USB_RST(USB_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EE_CS(EE_CS),
    .EE_SK(EE_SK), .EE_DO(EE_DO), .EE_DI(EE_DI), .CFG_LOAD_VALID(CFG_LOAD_VALID),
    .CFG_LOAD_ADDR(CFG_LOAD_ADDR), .CFG_LOAD_DATA(CFG_LOAD_DATA));
  sec_eeprom_model u_mem (.EE_CS(EE_CS), .EE_SK(EE_SK), .EE_DO(EE_DO), .present(present),
    .pull_lvl(pull_lvl), .slow(slow), .EE_DI(EE_DI));
  // ------
  // access tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    d = REG_RDATA;
  endtask : rd
  task automatic wait_idle();
    int n = 0;
    rd(SEC_CMD_OFS, v);
    while (v[SEC_BUSY_BIT] !== 1'b0 && n < 20000) begin
      rd(SEC_CMD_OFS, v);
      n++;
    end
    if (n == 20000) begin
      n_errors++;
      $display("ERROR %0t: busy stuck", $time);
    end
  endtask : wait_idle
  task automatic cmd(input sec_op_e op, input logic [8:0] a);
    wr(SEC_CMD_OFS, {1'b1, op, 19'h0, a});
    wait_idle();
  endtask : cmd
  task automatic rdbyte(input logic [8:0] a, input logic [7:0] e);
    wr(SEC_DATA_OFS, 32'h0);
    cmd(SEC_OP_READ, a);
    rd(SEC_DATA_OFS, v);
    chk(v, {24'h0, e});
  endtask : rdbyte
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // ------
  // load monitor
  // ------
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (CFG_LOAD_VALID === 1'b1) begin
      n_cfg <= n_cfg + 1;
      chk({24'h0, CFG_LOAD_DATA}, {24'h0, u_mem.mem[CFG_LOAD_ADDR]});
    end
  end
  // ------
  // sequence
  // ------
  initial begin
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    rd(SEC_CMD_OFS, v);
    chk(v & 32'hF000_01FF, 32'h8000_0000);
    wait_idle();
    chk(v, 32'h0000_0200);
    chk(n_cfg, 15);
    rd(12'h038, v);
    chk(v, 32'h0);
    wr(SEC_CMD_OFS, 32'h0000_0200);
    rd(SEC_CMD_OFS, v);
    chk(v, 32'h0);
    wr(SEC_DATA_OFS, 32'h3C);
    cmd(SEC_OP_WRITE, 9'h005);
    rdbyte(9'h005, 8'h10);
    cmd(SEC_OP_ERASE_WRITE_ENABLE, 9'h000);
    slow <= 1'b1;
    wr(SEC_DATA_OFS, 32'h3C);
    wr(SEC_CMD_OFS, {1'b1, SEC_OP_WRITE, 19'h0, 9'h1FF});
    repeat (2500) @(posedge MCLK);
    rd(SEC_CMD_OFS, v);
    chk(v, 32'hB000_01FF);
    wait_idle();
    slow <= 1'b0;
    rdbyte(9'h1FF, 8'h3C);
    cmd(SEC_OP_ERASE, 9'h1FF);
    rdbyte(9'h1FF, 8'hFF);
    wr(SEC_DATA_OFS, 32'h5A);
    cmd(SEC_OP_WRITE_ALL, 9'h000);
    rdbyte(9'h100, 8'h5A);
    cmd(SEC_OP_ERASE_ALL, 9'h000);
    rdbyte(9'h000, 8'hFF);
    t0 = n_cfg;
    cmd(SEC_OP_RELOAD, 9'h000);
    chk(v, 32'h7000_0000);
    chk(n_cfg, t0);
    wr(SEC_DATA_OFS, 32'hA5);
    cmd(SEC_OP_WRITE, 9'h000);
    cmd(SEC_OP_RELOAD, 9'h000);
    chk(v, 32'h7000_0200);
    chk(n_cfg, t0 + 15);
    cmd(SEC_OP_ERASE_WRITE_DISABLE, 9'h000);
    wr(SEC_DATA_OFS, 32'h11);
    cmd(SEC_OP_WRITE, 9'h003);
    rdbyte(9'h003, 8'hFF);
    present <= 1'b0;
    pull_lvl <= 1'b0;
    cmd(SEC_OP_READ, 9'h003);
    chk(v, 32'h0000_0203);
    wr(SEC_CMD_OFS, {1'b1, SEC_OP_WRITE, 19'h0, 9'h003});
    t0 = cyc;
    repeat (TOUT / 2) @(posedge MCLK);
    rd(SEC_CMD_OFS, v);
    chk(v, 32'hB000_0203);
    wait_idle();
    chk(v, 32'h3000_0603);
    chk((cyc - t0 >= TOUT) && (cyc - t0 < TOUT + 40), 32'h1);
    wr(SEC_CMD_OFS, 32'h0000_0400);
    rd(SEC_CMD_OFS, v);
    chk(v, 32'h0000_0200);
    pull_lvl <= 1'b1;
    cmd(SEC_OP_WRITE, 9'h003);
    chk(v, 32'h3000_0203);
    t0 = n_cfg;
    @(posedge MCLK);
    USB_RST <= 1'b1;
    @(posedge MCLK);
    USB_RST <= 1'b0;
    rd(SEC_CMD_OFS, v);
    chk({31'h0, v[SEC_BUSY_BIT]}, 32'h1);
    wait_idle();
    chk(n_cfg, t0);
    report_and_stop();
  end
  initial begin
    repeat (98000) @(posedge MCLK);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_top
